// File: hw/tor_map.vh
// Register indices, field layout and reset values of the timer output routing block
`ifndef TOR_MAP_VH
`define TOR_MAP_VH

// Word indices on the register bus (byte address = 4 * index)
`define TOR_ADDR_W          7
`define TOR_IDX_LINE_SEL0   7'h00
`define TOR_IDX_LINE_SEL1   7'h01
`define TOR_IDX_LINE_SEL2   7'h02
`define TOR_IDX_LINE_SEL3   7'h03
`define TOR_IDX_EMG_LO      7'h04
`define TOR_IDX_EMG_HI      7'h05
`define TOR_IDX_CONV_TRIG   7'h06
`define TOR_IDX_FLAGS_MISC  7'h07
`define TOR_IDX_FLAGS_GC    7'h08
`define TOR_IDX_FLAGS_LLO   7'h09
`define TOR_IDX_FLAGS_LHI   7'h0a
`define TOR_IDX_STATUS      7'h0b
// Local cell data registers occupy indices 0x40..0x7f
`define TOR_LDATA_BIT       6

// Reset values
`define TOR_RST_WORD        32'h00000000
`define TOR_RST_LDATA       16'h0000

// Writable and readable masks
`define TOR_MASK_ALL        32'hffffffff
`define TOR_MASK_EMG_HI     32'h7fffffff
`define TOR_MASK_CONV_TRIG  32'h0000ffff
`define TOR_MASK_FLAGS_MISC 32'h00007fff
`define TOR_LDATA_W         16

// Output line selector codes
`define TOR_SEL_W           2
`define TOR_SEL_RSVD        2'h0
`define TOR_SEL_GLOBAL      2'h1
`define TOR_SEL_LOCAL       2'h2
`define TOR_SEL_LOCAL_HI    2'h3

// Converter trigger selector fields
`define TOR_TRIG_SEL_W      4
`define TOR_TRIG_SRC_N      16
`define TOR_C0T0_LSB        0
`define TOR_C0T1_LSB        4
`define TOR_C1T0_LSB        8
`define TOR_C1T1_LSB        12

// Miscellaneous flag layout
`define TOR_ECC_N           4
`define TOR_ECC_STRIDE      3
`define TOR_ECC_RISE_OFS    0
`define TOR_ECC_FALL_OFS    1
`define TOR_ECC_CMP_OFS     2
`define TOR_PULSE_BIT       12
`define TOR_GT0_BIT         13
`define TOR_GT1_BIT         14

`endif

// File: hw/tor_sticky_flags.v
// Sticky request flag register with byte-lane software writes
`timescale 1ns/1ps
module tor_sticky_flags #(
	parameter [31:0] MASK = 32'hffffffff
) (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        wr_en,
	input  wire [3:0]  byteenable,
	input  wire [31:0] wdata,
	input  wire [31:0] evt,
	output reg  [31:0] flags_reg
);
	wire [31:0] lane_mask;
	wire [31:0] written;
	wire [31:0] flags_next;

	assign lane_mask  = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
	assign written    = (flags_reg & ~lane_mask) | (wdata & lane_mask);
	// Event is OR-ed after the write so a clearing write never hides it
	assign flags_next = ((wr_en ? written : flags_reg) | evt) & MASK;

	always @(posedge ref_clk) begin
		if (rst)
			flags_reg <= 32'h00000000;
		else
			flags_reg <= flags_next;
	end
endmodule

// File: hw/tor_routing.v
// Timer output routing, emergency shut-off, converter trigger select and request flags
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "tor_map.vh"
module tor_routing (
	ref_clk,
	rst,
	avs_address,
	avs_read,
	avs_write,
	avs_writedata,
	avs_byteenable,
	avs_readdata,
	avs_waitrequest,
	global_cell_out,
	local_cell_out,
	emergency_n_pin,
	trig_src,
	ecc_rise_evt,
	ecc_fall_evt,
	ecc_cmp_evt,
	pulse_done_evt,
	gt0_ovf_evt,
	gt1_ovf_evt,
	global_cell_evt,
	local_cell_evt,
	port_line_out,
	alt_function_select_line,
	conv0_start0,
	conv0_start1,
	conv1_start0,
	conv1_start1,
	emergency_active
);
	input  wire                         ref_clk;
	input  wire                         rst;
	input  wire [`TOR_ADDR_W-1:0]       avs_address;
	input  wire                         avs_read;
	input  wire                         avs_write;
	input  wire [31:0]                  avs_writedata;
	input  wire [3:0]                   avs_byteenable;
	output reg  [31:0]                  avs_readdata;
	output reg                          avs_waitrequest;
	input  wire [31:0]                  global_cell_out;
	input  wire [63:0]                  local_cell_out;
	input  wire                         emergency_n_pin;
	input  wire [`TOR_TRIG_SRC_N-1:0]   trig_src;
	input  wire [`TOR_ECC_N-1:0]        ecc_rise_evt;
	input  wire [`TOR_ECC_N-1:0]        ecc_fall_evt;
	input  wire [`TOR_ECC_N-1:0]        ecc_cmp_evt;
	input  wire                         pulse_done_evt;
	input  wire                         gt0_ovf_evt;
	input  wire                         gt1_ovf_evt;
	input  wire [31:0]                  global_cell_evt;
	input  wire [63:0]                  local_cell_evt;
	output reg  [63:0]                  port_line_out;
	output reg  [63:0]                  alt_function_select_line;
	output reg                          conv0_start0;
	output reg                          conv0_start1;
	output reg                          conv1_start0;
	output reg                          conv1_start1;
	output reg                          emergency_active;

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshake
	// Every access is answered one cycle after it is seen: waitrequest drops
	// for exactly one cycle, at which edge writes land and read data stands.

	wire        accept;
	wire        wr_acc;
	wire        is_ldata;
	wire [5:0]  ldata_idx;

	assign accept    = (avs_read | avs_write) & ~avs_waitrequest;
	assign wr_acc    = avs_write & ~avs_waitrequest;
	assign is_ldata  = avs_address[`TOR_LDATA_BIT];
	assign ldata_idx = avs_address[5:0];

	function [31:0] merge_be;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  be;
		input [31:0] mask;
		reg   [31:0] lanes;
		begin
			lanes    = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
			merge_be = ((old_val & ~lanes) | (new_val & lanes)) & mask;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	reg  [127:0] line_sel_reg;
	reg  [31:0]  emg_lo_reg;
	reg  [31:0]  emg_hi_reg;
	reg  [31:0]  conv_trig_reg;
	reg  [`TOR_LDATA_W-1:0] local_data_mem [0:63];
	wire [31:0]  ldata_merged;
	integer      i;

	assign ldata_merged = merge_be({16'h0000, local_data_mem[ldata_idx]},
		avs_writedata, avs_byteenable, `TOR_MASK_ALL);

	always @(posedge ref_clk) begin
		if (rst) begin
			line_sel_reg  <= {4{`TOR_RST_WORD}};
			emg_lo_reg    <= `TOR_RST_WORD;
			emg_hi_reg    <= `TOR_RST_WORD;
			conv_trig_reg <= `TOR_RST_WORD;
			for (i = 0; i < 64; i = i + 1)
				local_data_mem[i] <= `TOR_RST_LDATA;
		end else if (wr_acc) begin
			if (is_ldata) begin
				// Only the low two lanes exist; upper lanes are dropped
				local_data_mem[ldata_idx] <= ldata_merged[`TOR_LDATA_W-1:0];
			end else begin
				case (avs_address)
					`TOR_IDX_LINE_SEL0: line_sel_reg[31:0]   <= merge_be(line_sel_reg[31:0],
						avs_writedata, avs_byteenable, `TOR_MASK_ALL);
					`TOR_IDX_LINE_SEL1: line_sel_reg[63:32]  <= merge_be(line_sel_reg[63:32],
						avs_writedata, avs_byteenable, `TOR_MASK_ALL);
					`TOR_IDX_LINE_SEL2: line_sel_reg[95:64]  <= merge_be(line_sel_reg[95:64],
						avs_writedata, avs_byteenable, `TOR_MASK_ALL);
					`TOR_IDX_LINE_SEL3: line_sel_reg[127:96] <= merge_be(line_sel_reg[127:96],
						avs_writedata, avs_byteenable, `TOR_MASK_ALL);
					`TOR_IDX_EMG_LO:    emg_lo_reg    <= merge_be(emg_lo_reg,
						avs_writedata, avs_byteenable, `TOR_MASK_ALL);
					`TOR_IDX_EMG_HI:    emg_hi_reg    <= merge_be(emg_hi_reg,
						avs_writedata, avs_byteenable, `TOR_MASK_EMG_HI);
					`TOR_IDX_CONV_TRIG: conv_trig_reg <= merge_be(conv_trig_reg,
						avs_writedata, avs_byteenable, `TOR_MASK_CONV_TRIG);
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request flags

	wire [31:0] misc_evt;
	wire [31:0] flags_misc;
	wire [31:0] flags_gc;
	wire [31:0] flags_llo;
	wire [31:0] flags_lhi;
	wire        wr_misc;
	wire        wr_gc;
	wire        wr_llo;
	wire        wr_lhi;

	assign wr_misc = wr_acc & (avs_address == `TOR_IDX_FLAGS_MISC);
	assign wr_gc   = wr_acc & (avs_address == `TOR_IDX_FLAGS_GC);
	assign wr_llo  = wr_acc & (avs_address == `TOR_IDX_FLAGS_LLO);
	assign wr_lhi  = wr_acc & (avs_address == `TOR_IDX_FLAGS_LHI);

	genvar e;
	generate
		for (e = 0; e < `TOR_ECC_N; e = e + 1) begin : g_ecc
			assign misc_evt[e*`TOR_ECC_STRIDE+`TOR_ECC_RISE_OFS] = ecc_rise_evt[e];
			assign misc_evt[e*`TOR_ECC_STRIDE+`TOR_ECC_FALL_OFS] = ecc_fall_evt[e];
			assign misc_evt[e*`TOR_ECC_STRIDE+`TOR_ECC_CMP_OFS]  = ecc_cmp_evt[e];
		end
	endgenerate
	assign misc_evt[`TOR_PULSE_BIT] = pulse_done_evt;
	assign misc_evt[`TOR_GT0_BIT]   = gt0_ovf_evt;
	assign misc_evt[`TOR_GT1_BIT]   = gt1_ovf_evt;
	assign misc_evt[31:15]          = 17'h00000;

	tor_sticky_flags #(
		.MASK       (`TOR_MASK_FLAGS_MISC)
	) u_flags_misc (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.wr_en      (wr_misc),
		.byteenable (avs_byteenable),
		.wdata      (avs_writedata),
		.evt        (misc_evt),
		.flags_reg  (flags_misc)
	);

	tor_sticky_flags #(
		.MASK       (`TOR_MASK_ALL)
	) u_flags_gc (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.wr_en      (wr_gc),
		.byteenable (avs_byteenable),
		.wdata      (avs_writedata),
		.evt        (global_cell_evt),
		.flags_reg  (flags_gc)
	);

	tor_sticky_flags #(
		.MASK       (`TOR_MASK_ALL)
	) u_flags_llo (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.wr_en      (wr_llo),
		.byteenable (avs_byteenable),
		.wdata      (avs_writedata),
		.evt        (local_cell_evt[31:0]),
		.flags_reg  (flags_llo)
	);

	tor_sticky_flags #(
		.MASK       (`TOR_MASK_ALL)
	) u_flags_lhi (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.wr_en      (wr_lhi),
		.byteenable (avs_byteenable),
		.wdata      (avs_writedata),
		.evt        (local_cell_evt[63:32]),
		.flags_reg  (flags_lhi)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Emergency input: three-stage synchroniser, change taken when stages 2 and 3 agree

	reg emg_s1_reg;
	reg emg_s2_reg;
	reg emg_s3_reg;
	reg emg_n_level_reg;

	always @(posedge ref_clk) begin
		if (rst) begin
			emg_s1_reg      <= 1'b1;
			emg_s2_reg      <= 1'b1;
			emg_s3_reg      <= 1'b1;
			emg_n_level_reg <= 1'b1;
		end else begin
			emg_s1_reg <= emergency_n_pin;
			emg_s2_reg <= emg_s1_reg;
			emg_s3_reg <= emg_s2_reg;
			if (emg_s2_reg == emg_s3_reg)
				emg_n_level_reg <= emg_s3_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output line routing

	wire [63:0] pen_vec;
	wire [63:0] line_next;
	wire [63:0] as_next;

	// Line 63 has no enable bit and is never pulled down
	assign pen_vec = {1'b0, emg_hi_reg[30:0], emg_lo_reg};

	genvar g;
	generate
		for (g = 0; g < 64; g = g + 1) begin : g_line
			wire [`TOR_SEL_W-1:0] sel;
			assign sel = line_sel_reg[`TOR_SEL_W*g+1:`TOR_SEL_W*g];
			// Global index wraps so upper lines reuse global cells 0..31
			assign line_next[g] =
				(sel == `TOR_SEL_GLOBAL)   ? global_cell_out[g % 32] :
				(sel == `TOR_SEL_LOCAL)    ? local_cell_out[g] :
				(sel == `TOR_SEL_LOCAL_HI) ? local_cell_out[(g + 32) % 64] :
				1'b0;
			// Reserved code leaves the pin with general I/O
			assign as_next[g] = (sel != `TOR_SEL_RSVD) &
				~(~emg_n_level_reg & pen_vec[g]);
		end
	endgenerate

	always @(posedge ref_clk) begin
		if (rst) begin
			port_line_out            <= 64'h0000000000000000;
			alt_function_select_line <= 64'h0000000000000000;
			emergency_active         <= 1'b0;
		end else begin
			port_line_out            <= line_next;
			alt_function_select_line <= as_next;
			emergency_active         <= ~emg_n_level_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Converter start lines

	always @(posedge ref_clk) begin
		if (rst) begin
			conv0_start0 <= 1'b0;
			conv0_start1 <= 1'b0;
			conv1_start0 <= 1'b0;
			conv1_start1 <= 1'b0;
		end else begin
			conv0_start0 <= trig_src[conv_trig_reg[`TOR_C0T0_LSB+3:`TOR_C0T0_LSB]];
			conv0_start1 <= trig_src[conv_trig_reg[`TOR_C0T1_LSB+3:`TOR_C0T1_LSB]];
			conv1_start0 <= trig_src[conv_trig_reg[`TOR_C1T0_LSB+3:`TOR_C1T0_LSB]];
			conv1_start1 <= trig_src[conv_trig_reg[`TOR_C1T1_LSB+3:`TOR_C1T1_LSB]];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux and waitrequest

	reg [31:0] rdata_next;

	always @* begin
		rdata_next = 32'h00000000;
		if (is_ldata) begin
			rdata_next = {16'h0000, local_data_mem[ldata_idx]};
		end else begin
			case (avs_address)
				`TOR_IDX_LINE_SEL0:  rdata_next = line_sel_reg[31:0];
				`TOR_IDX_LINE_SEL1:  rdata_next = line_sel_reg[63:32];
				`TOR_IDX_LINE_SEL2:  rdata_next = line_sel_reg[95:64];
				`TOR_IDX_LINE_SEL3:  rdata_next = line_sel_reg[127:96];
				`TOR_IDX_EMG_LO:     rdata_next = emg_lo_reg;
				`TOR_IDX_EMG_HI:     rdata_next = emg_hi_reg & `TOR_MASK_EMG_HI;
				`TOR_IDX_CONV_TRIG:  rdata_next = conv_trig_reg & `TOR_MASK_CONV_TRIG;
				`TOR_IDX_FLAGS_MISC: rdata_next = flags_misc;
				`TOR_IDX_FLAGS_GC:   rdata_next = flags_gc;
				`TOR_IDX_FLAGS_LLO:  rdata_next = flags_llo;
				`TOR_IDX_FLAGS_LHI:  rdata_next = flags_lhi;
				`TOR_IDX_STATUS:     rdata_next = {31'h0, ~emg_n_level_reg};
				default:             rdata_next = 32'h00000000;
			endcase
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else if (accept) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_read | avs_write) begin
			avs_waitrequest <= 1'b0;
			// Writes leave the last read word standing
			if (avs_read)
				avs_readdata <= rdata_next;
		end
	end
endmodule

// File: bench/tor_checker_assertions.sv
// Port-level assertions for the timer output routing block
`timescale 1ns/1ps
module tor_checker (
	input wire        ref_clk,
	input wire        rst,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire [31:0] global_cell_out,
	input wire [63:0] local_cell_out,
	input wire        emergency_n_pin,
	input wire [15:0] trig_src,
	input wire [63:0] port_line_out,
	input wire [63:0] alt_function_select_line,
	input wire        conv0_start0,
	input wire        emergency_active
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	a_bus_ack_once: assert property (s_req |=> s_ack)
		else $error("bus answer not exactly one cycle");
	a_bus_no_ack: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
		else $error("answer without request");
	a_read_hold: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
		else $error("read data changed outside a read");
	a_reset_clear: assert property (disable iff (1'b0) rst |=> avs_waitrequest && port_line_out == 64'h0
		&& alt_function_select_line == 64'h0 && !emergency_active)
		else $error("outputs not cleared by reset");
	// Three sync flops, the filter and the output flop need exactly six samples
	a_emg_enter: assert property ((!emergency_n_pin) [*6] |-> emergency_active)
		else $error("emergency not taken");
	a_emg_leave: assert property (emergency_n_pin [*6] |-> !emergency_active)
		else $error("emergency not left");
	a_line_low_src: assert property (port_line_out[0] |->
		$past(global_cell_out[0] | local_cell_out[0] | local_cell_out[32]))
		else $error("line 0 high with no candidate high");
	a_line_high_src: assert property (port_line_out[40] |->
		$past(global_cell_out[8] | local_cell_out[40] | local_cell_out[8]))
		else $error("line 40 high with no candidate high");
	a_start_src: assert property (conv0_start0 |-> $past(trig_src) != 16'h0)
		else $error("start with no trigger candidate high");
endmodule
bind tor_routing tor_checker u_chk (.ref_clk(ref_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .global_cell_out(global_cell_out),
	.local_cell_out(local_cell_out), .emergency_n_pin(emergency_n_pin), .trig_src(trig_src),
	.port_line_out(port_line_out), .alt_function_select_line(alt_function_select_line),
	.conv0_start0(conv0_start0), .emergency_active(emergency_active));

// File: bench/tor_cell_model.sv
// Far side model: timer cell output levels and converter trigger candidates
`timescale 1ns/1ps
module tor_cell_model (
	input  wire        ref_clk,
	input  wire        rst,
	output reg  [31:0] global_cell_out = 32'h0,
	output reg  [63:0] local_cell_out = 64'h0,
	output reg  [15:0] trig_src = 16'h0
);
	reg [31:0] cnt_reg = 32'h0;
	// Levels change every cycle so a stale or wrong source pick shows at once
	always @(posedge ref_clk) begin
		if (rst)
			cnt_reg <= 32'h0;
		else
			cnt_reg <= cnt_reg + 32'h1;
		global_cell_out <= cnt_reg * 32'h9e3779b1;
		local_cell_out <= {cnt_reg * 32'h85ebca6b, ~(cnt_reg * 32'hc2b2ae35)};
		trig_src <= cnt_reg[15:0] ^ {cnt_reg[7:0], cnt_reg[15:8]};
	end
endmodule

// File: bench/testbench.sv
// Self-checking bench for the timer output routing block
`timescale 1ns/1ps
`include "tor_map.vh"
module testbench;
	reg          ref_clk = 1'b0;
	reg          rst = 1'b1;
	reg  [6:0]   avs_address = 7'h00;
	reg          avs_read = 1'b0;
	reg          avs_write = 1'b0;
	reg  [31:0]  avs_writedata = 32'h0;
	reg  [3:0]   avs_byteenable = 4'h0;
	reg          emergency_n_pin = 1'b1;
	reg  [110:0] evt = 111'h0;
	reg  [31:0]  rd_data;
	wire [31:0]  avs_readdata;
	wire         avs_waitrequest;
	wire [31:0]  global_cell_out;
	wire [63:0]  local_cell_out;
	wire [15:0]  trig_src;
	wire [63:0]  port_line_out;
	wire [63:0]  alt_function_select_line;
	wire         conv0_start0;
	wire         conv0_start1;
	wire         conv1_start0;
	wire         conv1_start1;
	wire         emergency_active;
	integer      bad_count = 0;
	integer      checked = 0;
	integer      i;
	always #10 ref_clk = ~ref_clk;
	tor_cell_model u_far (.ref_clk(ref_clk), .rst(rst), .global_cell_out(global_cell_out),
		.local_cell_out(local_cell_out), .trig_src(trig_src));
	tor_routing u_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .global_cell_out(global_cell_out),
		.local_cell_out(local_cell_out), .emergency_n_pin(emergency_n_pin), .trig_src(trig_src),
		.ecc_rise_evt(evt[3:0]), .ecc_fall_evt(evt[7:4]), .ecc_cmp_evt(evt[11:8]), .pulse_done_evt(evt[12]),
		.gt0_ovf_evt(evt[13]), .gt1_ovf_evt(evt[14]), .global_cell_evt(evt[46:15]),
		.local_cell_evt(evt[110:47]), .port_line_out(port_line_out),
		.alt_function_select_line(alt_function_select_line), .conv0_start0(conv0_start0),
		.conv0_start1(conv0_start1), .conv1_start0(conv1_start0), .conv1_start1(conv1_start1),
		.emergency_active(emergency_active));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [63:0] got, input logic [63:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// One access; events are dropped at the completion edge so a held event meets the write
	task bus(input logic wr, input logic [6:0] a, input logic [31:0] d, input logic [3:0] be);
		begin
			avs_address <= a;
			avs_writedata <= d;
			avs_byteenable <= be;
			avs_write <= wr;
			avs_read <= !wr;
			@(posedge ref_clk);
			while (avs_waitrequest !== 1'b0)
				@(posedge ref_clk);
			rd_data = avs_readdata;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			evt <= 111'h0;
			@(posedge ref_clk);
		end
	endtask
	task rd_chk(input logic [6:0] a, input logic [31:0] exp);
		begin
			bus(1'b0, a, 32'h0, 4'hf);
			chk(rd_data, exp);
		end
	endtask
	task pulse(input logic [110:0] v);
		begin
			evt <= v;
			@(posedge ref_clk);
			evt <= 111'h0;
			@(posedge ref_clk);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task reset_chk;
		begin
			for (i = 0; i < 12; i = i + 1)
				rd_chk(i[6:0], 32'h0);
			rd_chk(7'h45, 32'h0);
			bus(1'b1, 7'h0c, 32'hffffffff, 4'hf);
			rd_chk(7'h0c, 32'h0);
			bus(1'b1, 7'h45, 32'hffffffff, 4'hf);
			rd_chk(7'h45, 32'h0000ffff);
			bus(1'b1, 7'h45, 32'h00001234, 4'h2);
			rd_chk(7'h45, 32'h000012ff);
			bus(1'b1, `TOR_IDX_FLAGS_MISC, 32'hffffffff, 4'hf);
			rd_chk(`TOR_IDX_FLAGS_MISC, 32'h00007fff);
			bus(1'b1, `TOR_IDX_FLAGS_MISC, 32'h0, 4'hf);
		end
	endtask
	task line_chk(input logic [1:0] c);
		reg [31:0] g;
		reg [63:0] l;
		reg [63:0] e;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1)
				bus(1'b1, k[6:0], {16{c}}, 4'hf);
			@(negedge ref_clk);
			g = global_cell_out;
			l = local_cell_out;
			for (k = 0; k < 64; k = k + 1)
				e[k] = (c == 2'h1) ? g[k % 32] : (c == 2'h2) ? l[k] : (c == 2'h3) ? l[(k + 32) % 64] : 1'b0;
			@(negedge ref_clk);
			chk(port_line_out, e);
			chk(alt_function_select_line, {64{c != 2'h0}});
			@(posedge ref_clk);
		end
	endtask
	task emg_chk;
		begin
			bus(1'b1, `TOR_IDX_EMG_LO, 32'h0000ffff, 4'hf);
			bus(1'b1, `TOR_IDX_EMG_HI, 32'hffffffff, 4'hf);
			rd_chk(`TOR_IDX_EMG_HI, 32'h7fffffff);
			emergency_n_pin <= 1'b0;
			repeat (6) @(posedge ref_clk);
			@(negedge ref_clk);
			chk(alt_function_select_line, 64'h80000000ffff0000);
			chk(emergency_active, 64'h1);
			@(posedge ref_clk);
			rd_chk(`TOR_IDX_STATUS, 32'h1);
			emergency_n_pin <= 1'b1;
			repeat (6) @(posedge ref_clk);
			@(negedge ref_clk);
			chk(alt_function_select_line, {64{1'b1}});
			chk(emergency_active, 64'h0);
			@(posedge ref_clk);
			line_chk(2'h0);
		end
	endtask
	task trig_chk;
		reg [15:0] t;
		begin
			bus(1'b1, `TOR_IDX_CONV_TRIG, 32'hffffa50f, 4'hf);
			rd_chk(`TOR_IDX_CONV_TRIG, 32'h0000a50f);
			repeat (4) begin
				@(negedge ref_clk);
				t = trig_src;
				@(negedge ref_clk);
				chk({conv0_start0, conv0_start1, conv1_start0, conv1_start1}, {t[15], t[0], t[5], t[10]});
			end
			@(posedge ref_clk);
		end
	endtask
	task flag_chk;
		begin
			pulse({64'h8000000100000001, 32'h80000001, 15'h595a});
			rd_chk(`TOR_IDX_FLAGS_MISC, 32'h00005a8e);
			rd_chk(`TOR_IDX_FLAGS_GC, 32'h80000001);
			rd_chk(`TOR_IDX_FLAGS_LLO, 32'h00000001);
			rd_chk(`TOR_IDX_FLAGS_LHI, 32'h80000001);
			pulse({96'h0, 15'h26a5});
			rd_chk(`TOR_IDX_FLAGS_MISC, 32'h00007fff);
			evt <= {96'h0, 15'h2000};
			bus(1'b1, `TOR_IDX_FLAGS_MISC, 32'h0, 4'hf);
			rd_chk(`TOR_IDX_FLAGS_MISC, 32'h00002000);
			bus(1'b1, `TOR_IDX_FLAGS_MISC, 32'h0, 4'hf);
			rd_chk(`TOR_IDX_FLAGS_MISC, 32'h0);
			bus(1'b1, `TOR_IDX_FLAGS_GC, 32'h00000010, 4'h1);
			rd_chk(`TOR_IDX_FLAGS_GC, 32'h80000010);
		end
	endtask
	// Reset in mid-run must wipe configuration, flags and local data again
	task reset_mid_chk;
		begin
			rst <= 1'b1;
			repeat (2) @(posedge ref_clk);
			rst <= 1'b0;
			@(posedge ref_clk);
			rd_chk(`TOR_IDX_EMG_LO, 32'h0);
			rd_chk(`TOR_IDX_EMG_HI, 32'h0);
			rd_chk(`TOR_IDX_CONV_TRIG, 32'h0);
			rd_chk(`TOR_IDX_FLAGS_GC, 32'h0);
			rd_chk(7'h45, 32'h0);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task end_sim;
		begin
			if (bad_count == 0 && checked > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		reset_chk;
		for (i = 1; i < 4; i = i + 1)
			line_chk(i[1:0]);
		emg_chk;
		trig_chk;
		flag_chk;
		reset_mid_chk;
		end_sim;
	end
	// The sequence needs well under a thousand cycles; ten thousand means a hang
	initial begin
		#200000;
		bad_count = bad_count + 1;
		end_sim;
	end
endmodule
